// [ocr_defines.svh]
// Offsets, field positions, reset values and masks of the control bank
`ifndef OCR_DEFINES_SVH
`define OCR_DEFINES_SVH

`define OCR_ADDR_W 16
`define OCR_DATA_W 8
`define OCR_NUM_REGS 6

// Register byte addresses
`define OCR_GLOBAL_OFF 16'h2000
`define OCR_REFPD_OFF 16'h2001
`define OCR_TIMEOUT_OFF 16'h2002
`define OCR_FAULT_OFF 16'h2003
`define OCR_BYPASS_OFF 16'h2004
`define OCR_IRQCLR_OFF 16'h2005
`define OCR_UPDATE_OFF 16'h000F
`define OCR_STATUS_OFF 16'h20F0

// Reset values
`define OCR_RST_VAL 8'h00
`define OCR_RDATA_IDLE 8'h00

// Implemented-bit masks; reserved bits read as zero
`define OCR_MASK_NIBBLE 8'h0F
`define OCR_MASK_IRQCLR 8'h8F
`define OCR_MASK_NONE 8'h00

// Global control fields
`define OCR_GC_PD_ALL 0
`define OCR_GC_CAL_ALL 1
`define OCR_GC_CAL_SYS 2
`define OCR_GC_SYNC_ALL 3

// Per-reference bit order: A, A comp, B, B comp
`define OCR_REF_A 0
`define OCR_REF_A_COMP 1
`define OCR_REF_B 2
`define OCR_REF_B_COMP 3

// Interrupt clear fields
`define OCR_IC_ALL 0
`define OCR_IC_COMMON 1
`define OCR_IC_LOOP0 2
`define OCR_IC_LOOP1 3
`define OCR_IC_WDOG 7

// Update strobe field
`define OCR_UPD_BIT 0

`endif

// [ocr_pkg.sv]
// Types shared by the operational control bank
package ocr_pkg;

  typedef logic [15:0] ocr_addr_t;
  typedef logic [7:0] ocr_byte_t;
  typedef logic [3:0] ocr_ref_vec_t;

  typedef enum logic [2:0]
  {
    OCR_IDX_GLOBAL = 3'b000,
    OCR_IDX_REFPD = 3'b001,
    OCR_IDX_TIMEOUT = 3'b010,
    OCR_IDX_FAULT = 3'b011,
    OCR_IDX_BYPASS = 3'b100,
    OCR_IDX_IRQCLR = 3'b101
  } ocr_reg_idx_t;

endpackage : ocr_pkg

// [ocr_stage_reg.sv]
// Staged control register with active copy and self-clearing bits
`timescale 1ns/10ps
`include "ocr_defines.svh"

module ocr_stage_reg #(
  parameter logic [7:0] MASK = `OCR_MASK_NIBBLE,
  parameter logic [7:0] AUTOCLR = `OCR_MASK_NONE
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Software side
  input wire logic wr_en,
  input wire ocr_pkg::ocr_byte_t wdata,
  input wire logic update,
  // Copies
  output ocr_pkg::ocr_byte_t stage_q,
  output ocr_pkg::ocr_byte_t active_q
);
  import ocr_pkg::*;

  ocr_byte_t stage_d;
  ocr_byte_t active_d;

  // Self-clearing bits leave the staging copy once transferred, so the
  // same command is never applied twice by a later update.
  assign stage_d = wr_en ? (wdata & MASK)
                 : update ? (stage_q & ~AUTOCLR) : stage_q;
  // Self-clearing bits stand in the active copy for one cycle only
  assign active_d = update ? stage_q : (active_q & ~AUTOCLR);

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      stage_q <= `OCR_RST_VAL;
      active_q <= `OCR_RST_VAL;
    end
    else
    begin
      stage_q <= stage_d;
      active_q <= active_d;
    end
  end

endmodule : ocr_stage_reg

// [ocr_rise_det.sv]
// Registered rising-edge detector, one pulse per 0-to-1 change
`timescale 1ns/10ps

module ocr_rise_det #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Level in, pulse out
  input wire logic [W-1:0] level,
  output logic [W-1:0] pulse_q
);

  logic [W-1:0] prev_q;
  logic [W-1:0] pulse_d;

  assign pulse_d = level & ~prev_q;

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      prev_q <= '0;
      pulse_q <= '0;
    end
    else
    begin
      prev_q <= level;
      pulse_q <= pulse_d;
    end
  end

endmodule : ocr_rise_det

// [ocr_ctrl_bank.sv]
// Operational control register bank with staged update
//
// Added by the designer: the plain strobed port.
`timescale 1ns/10ps
`include "ocr_defines.svh"

module ocr_ctrl_bank (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Register port
  input wire ocr_pkg::ocr_addr_t reg_addr,
  input wire ocr_pkg::ocr_byte_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output ocr_pkg::ocr_byte_t reg_rdata,
  // Reference monitor state
  input wire ocr_pkg::ocr_ref_vec_t ref_unfaulted,
  input wire ocr_pkg::ocr_ref_vec_t ref_timer_running,
  // Global controls
  output logic divider_sync_hold,
  output logic chip_power_down,
  output logic cal_start_system_clock_loop,
  output logic cal_start_analog_loop_zero,
  output logic cal_start_analog_loop_one,
  // Reference controls
  output ocr_pkg::ocr_ref_vec_t ref_rx_power_down,
  output ocr_pkg::ocr_ref_vec_t ref_fault_force,
  output ocr_pkg::ocr_ref_vec_t ref_monitor_bypass,
  output ocr_pkg::ocr_ref_vec_t ref_validate_now,
  // Interrupt and watchdog controls
  output logic irq_clear_all,
  output logic irq_clear_common,
  output logic irq_clear_loop_zero,
  output logic irq_clear_loop_one,
  output logic watchdog_restart
);
  import ocr_pkg::*;

  localparam logic [47:0] MASK_V = {
    `OCR_MASK_IRQCLR, `OCR_MASK_NIBBLE, `OCR_MASK_NIBBLE,
    `OCR_MASK_NIBBLE, `OCR_MASK_NIBBLE, `OCR_MASK_NIBBLE
  };
  localparam logic [47:0] AUTOCLR_V = {
    `OCR_MASK_IRQCLR, `OCR_MASK_NONE, `OCR_MASK_NONE,
    `OCR_MASK_NIBBLE, `OCR_MASK_NONE, `OCR_MASK_NONE
  };

  // Offset of each bank register
  function automatic ocr_addr_t reg_offset(input ocr_reg_idx_t idx);
    ocr_addr_t off;
    off = `OCR_GLOBAL_OFF;
    case (idx)
      OCR_IDX_GLOBAL: off = `OCR_GLOBAL_OFF;
      OCR_IDX_REFPD: off = `OCR_REFPD_OFF;
      OCR_IDX_TIMEOUT: off = `OCR_TIMEOUT_OFF;
      OCR_IDX_FAULT: off = `OCR_FAULT_OFF;
      OCR_IDX_BYPASS: off = `OCR_BYPASS_OFF;
      OCR_IDX_IRQCLR: off = `OCR_IRQCLR_OFF;
      default: off = `OCR_GLOBAL_OFF;
    endcase
    return off;
  endfunction : reg_offset

  // Address match, shared by the write and read paths
  function automatic logic reg_hit(input ocr_addr_t addr,
                                   input ocr_addr_t off);
    return addr == off;
  endfunction : reg_hit

  logic [5:0] wr_sel;
  logic [5:0] rd_sel;
  ocr_byte_t stage_v [6];
  ocr_byte_t active_v [6];
  logic upd_hit;
  logic upd_pulse;
  logic status_hit;
  ocr_byte_t status_word;
  ocr_byte_t rd_mux;
  ocr_byte_t rdata_d;
  ocr_byte_t rdata_q;
  ocr_byte_t gc_act;
  ocr_byte_t to_act;
  ocr_byte_t ic_act;
  logic cal_sys_req;
  logic cal_all_pulse;
  logic cal_sys_pulse;
  ocr_ref_vec_t validate_d;
  ocr_ref_vec_t validate_q;

  genvar gi;
  generate
    for (gi = 0; gi < `OCR_NUM_REGS; gi++)
    begin : g_reg
      assign wr_sel[gi] = reg_wr &&
        reg_hit(reg_addr, reg_offset(ocr_reg_idx_t'(gi)));
      assign rd_sel[gi] = reg_rd &&
        reg_hit(reg_addr, reg_offset(ocr_reg_idx_t'(gi)));

      ocr_stage_reg #(
        .MASK(MASK_V[gi*8 +: 8]),
        .AUTOCLR(AUTOCLR_V[gi*8 +: 8])
      ) u_reg (
        .core_clk(core_clk),
        .rstn(rstn),
        .wr_en(wr_sel[gi]),
        .wdata(reg_wdata),
        .update(upd_pulse),
        .stage_q(stage_v[gi]),
        .active_q(active_v[gi])
      );
    end
  endgenerate

  // update strobe write transfers staging to active
  assign upd_hit = reg_wr && reg_hit(reg_addr, `OCR_UPDATE_OFF);
  // only a 1 in the strobe bit counts
  assign upd_pulse = upd_hit && reg_wdata[`OCR_UPD_BIT];

  assign gc_act = active_v[OCR_IDX_GLOBAL];
  assign to_act = active_v[OCR_IDX_TIMEOUT];
  assign ic_act = active_v[OCR_IDX_IRQCLR];

  // divider hold follows the active sync-all bit
  assign divider_sync_hold = gc_act[`OCR_GC_SYNC_ALL];
  // power-down never gates the register port logic
  assign chip_power_down = gc_act[`OCR_GC_PD_ALL];

  // system-clock request is an OR of both calibrate bits
  assign cal_sys_req = gc_act[`OCR_GC_CAL_SYS] | gc_act[`OCR_GC_CAL_ALL];

  // calibration fires on the rising edge only
  ocr_rise_det #(
    .W(1)
  ) u_cal_sys (
    .core_clk(core_clk),
    .rstn(rstn),
    .level(cal_sys_req),
    .pulse_q(cal_sys_pulse)
  );

  // calibrate-all edge for the analog loops
  ocr_rise_det #(
    .W(1)
  ) u_cal_all (
    .core_clk(core_clk),
    .rstn(rstn),
    .level(gc_act[`OCR_GC_CAL_ALL]),
    .pulse_q(cal_all_pulse)
  );

  // system clock loop is covered through the OR request
  assign cal_start_system_clock_loop = cal_sys_pulse;
  assign cal_start_analog_loop_zero = cal_all_pulse;
  assign cal_start_analog_loop_one = cal_all_pulse;

  // A, complementary A, B and complementary B receiver power-down
  assign ref_rx_power_down = active_v[OCR_IDX_REFPD][3:0];
  assign ref_fault_force = active_v[OCR_IDX_FAULT][3:0];
  assign ref_monitor_bypass = active_v[OCR_IDX_BYPASS][3:0];

  // validate only an unfaulted reference whose timer runs
  assign validate_d = to_act[3:0] & ref_unfaulted & ref_timer_running;

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      validate_q <= '0;
    end
    else
    begin
      validate_q <= validate_d;
    end
  end

  assign ref_validate_now = validate_q;

  // one-cycle clear commands from the self-clearing bits
  assign irq_clear_all = ic_act[`OCR_IC_ALL];
  assign irq_clear_common = ic_act[`OCR_IC_COMMON];
  assign irq_clear_loop_zero = ic_act[`OCR_IC_LOOP0];
  assign irq_clear_loop_one = ic_act[`OCR_IC_LOOP1];
  assign watchdog_restart = ic_act[`OCR_IC_WDOG];

  // Status shows what the downstream logic currently sees
  assign status_hit = reg_rd && reg_hit(reg_addr, `OCR_STATUS_OFF);
  assign status_word = {ref_rx_power_down, gc_act[3:0]};

  // Bank reads return staged values, status reads active ones; unmapped addresses read as zero
  always_comb
  begin
    rd_mux = `OCR_RDATA_IDLE;
    for (int i = 0; i < `OCR_NUM_REGS; i++)
    begin
      if (rd_sel[i])
      begin
        rd_mux = stage_v[i];
      end
    end
    if (status_hit)
    begin
      rd_mux = status_word;
    end
  end

  // Data stands only in the cycle after the read strobe
  assign rdata_d = reg_rd ? rd_mux : `OCR_RDATA_IDLE;

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      rdata_q <= `OCR_RDATA_IDLE;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

endmodule : ocr_ctrl_bank

// [ocr_ctrl_bank_monitor.sv]
// Port-level checks of the operational control bank
`timescale 1ns/10ps
`include "ocr_defines.svh"

module ocr_ctrl_bank_monitor (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Register port
  input wire ocr_pkg::ocr_addr_t reg_addr,
  input wire ocr_pkg::ocr_byte_t reg_wdata,
  input wire logic reg_wr,
  // Controls
  input wire ocr_pkg::ocr_ref_vec_t ref_unfaulted,
  input wire ocr_pkg::ocr_ref_vec_t ref_timer_running,
  input wire logic divider_sync_hold,
  input wire logic chip_power_down,
  input wire logic cal_start_system_clock_loop,
  input wire logic cal_start_analog_loop_zero,
  input wire logic cal_start_analog_loop_one,
  input wire ocr_pkg::ocr_ref_vec_t ref_rx_power_down,
  input wire ocr_pkg::ocr_ref_vec_t ref_fault_force,
  input wire ocr_pkg::ocr_ref_vec_t ref_validate_now,
  input wire logic watchdog_restart
);
  import ocr_pkg::*;
  wire logic upd = reg_wr && reg_addr == `OCR_UPDATE_OFF && reg_wdata[0];
  // Gate seen one cycle before a validate pulse
  wire ocr_ref_vec_t gate = ref_unfaulted & ref_timer_running;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  hold_staged_a: assert property (
    $changed(divider_sync_hold) |-> $past(upd))
    else $error("sync hold moved without update");
  power_staged_a: assert property (
    $changed(chip_power_down) |-> $past(upd))
    else $error("power down moved without update");
  refpd_staged_a: assert property (
    $changed(ref_rx_power_down) |-> $past(upd))
    else $error("receiver power down moved without update");
  fault_staged_a: assert property (
    $changed(ref_fault_force) |-> $past(upd))
    else $error("fault force moved without update");
  cal_cause_a: assert property (
    cal_start_system_clock_loop |-> $past(upd, 2))
    else $error("calibration pulse without update");
  cal_pulse_a: assert property (
    cal_start_system_clock_loop |=> !cal_start_system_clock_loop)
    else $error("calibration pulse too long");
  cal_all_a: assert property (
    cal_start_analog_loop_zero |->
    cal_start_system_clock_loop && cal_start_analog_loop_one)
    else $error("calibrate all pulses split");
  val_gate_a: assert property (
    (ref_validate_now & ~$past(gate)) == 4'h0)
    else $error("validate pulse on gated reference");
  val_cause_a: assert property (
    |ref_validate_now |-> $past(upd, 2))
    else $error("validate pulse without update");
  wdog_pulse_a: assert property (
    watchdog_restart |-> $past(upd) ##1 !watchdog_restart)
    else $error("watchdog restart malformed");

  cover property (cal_start_analog_loop_zero);
  cover property (|ref_validate_now);
  cover property (watchdog_restart);
endmodule : ocr_ctrl_bank_monitor

// [tb_ocr_ctrl_bank.sv]
// Directed register tests of the operational control bank
`timescale 1ns/10ps
`include "ocr_defines.svh"

module tb_ocr_ctrl_bank;
  import ocr_pkg::*;
  localparam ocr_addr_t gl = `OCR_GLOBAL_OFF;
  localparam ocr_addr_t pd = `OCR_REFPD_OFF;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  ocr_addr_t reg_addr = 16'h0000;
  ocr_byte_t reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  ocr_byte_t reg_rdata;
  ocr_ref_vec_t ref_unfaulted = 4'h0;
  ocr_ref_vec_t ref_timer_running = 4'h0;
  logic hold, pdn, c_sys, c_a0, c_a1;
  ocr_ref_vec_t rx_pd, flt, byp, val;
  wire logic [4:0] irq;
  logic [4:0] irq_acc = 5'h00;
  ocr_ref_vec_t val_acc = 4'h0;
  int cnt_sys = 0;
  int cnt_ana = 0;
  int error_cnt = 0;
  int tests_run = 0;
  wire logic [7:0] lv = {2'b00, hold, pdn, rx_pd};

  always #5 core_clk = ~core_clk;

  ocr_ctrl_bank i_dut (.core_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .ref_unfaulted, .ref_timer_running,
    .divider_sync_hold(hold), .chip_power_down(pdn),
    .cal_start_system_clock_loop(c_sys), .cal_start_analog_loop_zero(c_a0),
    .cal_start_analog_loop_one(c_a1), .ref_rx_power_down(rx_pd),
    .ref_fault_force(flt), .ref_monitor_bypass(byp), .ref_validate_now(val),
    .irq_clear_all(irq[0]), .irq_clear_common(irq[1]),
    .irq_clear_loop_zero(irq[2]), .irq_clear_loop_one(irq[3]),
    .watchdog_restart(irq[4]));

  // Pulses are one cycle wide, so tally them on every edge
  always @(posedge core_clk)
    if (rstn)
    begin
      cnt_sys <= cnt_sys + c_sys;
      cnt_ana <= cnt_ana + c_a0 + c_a1;
      val_acc <= val_acc | val;
      irq_acc <= irq_acc | irq;
    end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input ocr_addr_t a, input ocr_byte_t d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input ocr_addr_t a, input ocr_byte_t e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask : rd

  // Update strobe, then let level outputs settle
  task automatic upd;
    wr(`OCR_UPDATE_OFF, 8'h01);
    @(posedge core_clk);
    #1;
  endtask : upd

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict

  initial
  begin
    #50000;
    error_cnt++;
    print_verdict;
  end

  initial
  begin
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 6; i++)
      rd(gl + 16'(i), 8'h00);
    chk(lv, 8'h00);
    $display("test reset done");
    wr(gl, 8'hF9);
    rd(gl, 8'h09);
    wr(`OCR_UPDATE_OFF, 8'h00);
    // A wrongly taken update would show one step after this edge
    #1;
    chk(lv, 8'h00);
    upd;
    chk(lv, 8'h30);
    rd(gl, 8'h09);
    // Read data stands one cycle only, then idles at zero
    @(posedge core_clk);
    #1;
    chk(reg_rdata, 8'h00);
    wr(gl, 8'h00);
    upd;
    chk(lv, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      wr(pd, ocr_byte_t'(8'h01 << i));
      upd;
      chk(lv, ocr_byte_t'(8'h01 << i));
    end
    wr(pd, 8'hF0);
    rd(pd, 8'h00);
    wr(16'h2006, 8'hFF);
    rd(16'h2006, 8'h00);
    wr(`OCR_FAULT_OFF, 8'hFA);
    wr(`OCR_BYPASS_OFF, 8'h05);
    upd;
    chk({flt, byp}, 8'hA5);
    $display("test levels done");
    wr(gl, 8'h04);
    upd;
    upd;
    repeat (2) @(posedge core_clk);
    chk({8'(cnt_sys), 8'(cnt_ana)}, 16'h0100);
    wr(gl, 8'h00);
    upd;
    wr(gl, 8'h02);
    upd;
    wr(gl, 8'h06);
    upd;
    repeat (2) @(posedge core_clk);
    chk({8'(cnt_sys), 8'(cnt_ana)}, 16'h0202);
    // Status shows active global bits and receiver power-down
    rd(`OCR_STATUS_OFF, 8'h06);
    $display("test calibration done");
    ref_unfaulted <= 4'h5;
    ref_timer_running <= 4'h7;
    wr(`OCR_TIMEOUT_OFF, 8'h0F);
    upd;
    upd;
    repeat (2) @(posedge core_clk);
    chk({4'h0, val_acc}, 8'h05);
    rd(`OCR_TIMEOUT_OFF, 8'h00);
    wr(`OCR_IRQCLR_OFF, 8'hFF);
    rd(`OCR_IRQCLR_OFF, 8'h8F);
    upd;
    repeat (2) @(posedge core_clk);
    chk({3'h0, irq_acc}, 8'h1F);
    rd(`OCR_IRQCLR_OFF, 8'h00);
    $display("test pulses done");
    print_verdict;
  end
endmodule : tb_ocr_ctrl_bank

bind ocr_ctrl_bank ocr_ctrl_bank_monitor i_mon (.core_clk, .rstn, .reg_addr,
  .reg_wdata, .reg_wr, .ref_unfaulted, .ref_timer_running,
  .divider_sync_hold, .chip_power_down, .cal_start_system_clock_loop,
  .cal_start_analog_loop_zero, .cal_start_analog_loop_one,
  .ref_rx_power_down, .ref_fault_force, .ref_validate_now,
  .watchdog_restart);
